// ===== logic/serial_attenuator_control.sv
// three-wire control of a three-channel attenuator with daisy chain
`timescale 1ns/100ps
module serial_attenuator_control #(
	parameter int CHANNELS = atten_pkg::CHANNELS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic frame_en_n,
	output logic sdo,
	output atten_pkg::frame_t held_frame,
	output atten_pkg::channel_setting_t [CHANNELS-1:0] chan
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [2:0] pins_s;
	logic en_n_s;
	logic sclk_s;
	logic sdi_s;
	logic sclk_prev_q;
	logic en_prev_q;
	logic shift_rise;
	logic shifting;
	logic load_rise;
	logic [atten_pkg::FRAME_BITS-1:0] shift_q;
	logic sdo_q;
	atten_pkg::frame_t latch_q;
	atten_pkg::ctrl_state_t state_q;
	atten_pkg::ctrl_state_t state_d;
	logic [CHANNELS-1:0] hit_q;
	atten_pkg::channel_setting_t new_q;
	atten_pkg::channel_setting_t [CHANNELS-1:0] chan_q;
	logic seen_apply_q;

	// reset enters asynchronously but is released through two flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_q <= atten_pkg::RST_SYNC_RESET;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	// link pins come from the host's clock, so resample them first
	pin_sync #(
		.WIDTH(atten_pkg::PIN_COUNT),
		.RESET_VAL(atten_pkg::PIN_RESET)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pins({frame_en_n, sclk, sdi}),
		.synced(pins_s)
	);

	assign en_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign sdi_s = pins_s[0];

	// previous samples for edge finding on clean copies only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_prev_q <= 1'b0;
			en_prev_q <= 1'b1;
		end
		else
		begin
			sclk_prev_q <= sclk_s;
			en_prev_q <= en_n_s;
		end
	end

	// data is taken only on a link clock rise with the enable low
	assign shift_rise = sclk_s & ~sclk_prev_q;
	assign shifting = shift_rise & ~en_n_s;
	assign load_rise = en_n_s & ~en_prev_q;

	// msb enters first, so after 16 bits byte 0 sits on top
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= atten_pkg::SHIFT_RESET;
		else if (shifting)
			shift_q <= {shift_q[atten_pkg::FRAME_BITS-2:0], sdi_s};
	end

	// chain output shows the top bit, held between link clocks so the
	// next device samples the previous bit on its own rising edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sdo_q <= 1'b0;
		else if (shifting)
			sdo_q <= shift_q[atten_pkg::FRAME_BITS-2];
	end

	// holding latch keeps the frame while new bits shift through
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			latch_q <= atten_pkg::frame_t'(atten_pkg::SHIFT_RESET);
		else if (load_rise)
			latch_q <= atten_pkg::frame_t'(shift_q);
	end

	// sequence: latch, decode, then switch the selected channel
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			atten_pkg::ST_IDLE:
				if (load_rise)
					state_d = atten_pkg::ST_LATCHED;
			atten_pkg::ST_LATCHED:
				state_d = atten_pkg::ST_APPLY;
			atten_pkg::ST_APPLY:
				state_d = atten_pkg::ST_IDLE;
			default:
				state_d = atten_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= atten_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	// decode stage: address to channel hits, code to tap and level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hit_q <= '0;
			new_q <= atten_pkg::MUTE_SETTING;
		end
		else if (state_q == atten_pkg::ST_LATCHED)
		begin
			for (int i = 0; i < CHANNELS; i++)
				hit_q[i] <= atten_pkg::channel_hit(latch_q.addr,
					8'(i));
			if (latch_q.code >= atten_pkg::MUTE_FIRST)
				new_q <= atten_pkg::MUTE_SETTING;
			else
			begin
				new_q.mute <= 1'b0;
				new_q.tap <= latch_q.code[6:0];
				new_q.level_hdb <=
					atten_pkg::code_to_hdb(latch_q.code);
			end
		end
	end

	// only hit channels switch; no hit at all leaves everything alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			chan_q <= {CHANNELS{atten_pkg::MUTE_SETTING}};
		else if (state_q == atten_pkg::ST_APPLY)
		begin
			for (int i = 0; i < CHANNELS; i++)
				if (hit_q[i])
					chan_q[i] <= new_q;
		end
	end

	// mute is a separate disconnect flag, not just the deepest tap
	assign chan = chan_q;
	assign sdo = sdo_q;
	assign held_frame = latch_q;

	// helper for checking the power-up state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			seen_apply_q <= 1'b0;
		else if (state_q == atten_pkg::ST_APPLY)
			seen_apply_q <= 1'b1;
	end

	shift_in_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(sclk_s && !sclk_prev_q && !en_n_s) |=>
		shift_q == {$past(shift_q[atten_pkg::FRAME_BITS-2:0]),
			$past(sdi_s)})
		else $error("shift register missed a link clock bit");

	shift_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(en_n_s || !(sclk_s && !sclk_prev_q)) |=> $stable(shift_q))
		else $error("shift register moved without a qualified edge");

	chain_out_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		shifting |=> sdo == $past(shift_q[atten_pkg::FRAME_BITS-2])
			&& sdo == shift_q[atten_pkg::FRAME_BITS-1])
		else $error("chain output does not show the outgoing bit");

	latch_capture_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(en_n_s && !en_prev_q) |=> held_frame == $past(shift_q))
		else $error("enable rise did not capture the shift register");

	decode_order_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(load_rise && state_q == atten_pkg::ST_IDLE) |=>
		state_q == atten_pkg::ST_LATCHED ##1
		state_q == atten_pkg::ST_APPLY ##1
		state_q == atten_pkg::ST_IDLE)
		else $error("latch, decode and apply out of sequence");

	quiet_chan_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		state_q != atten_pkg::ST_APPLY |=> $stable(chan_q))
		else $error("channel changed without an applied frame");

	power_mute_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!seen_apply_q |-> chan_q == {CHANNELS{atten_pkg::MUTE_SETTING}})
		else $error("channel not muted before the first frame");

	latch_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!load_rise |=> $stable(held_frame))
		else $error("holding latch moved without an enable rise");

	chain_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!shifting |=> $stable(sdo))
		else $error("chain output moved without a shift");

	one_hit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		state_q == atten_pkg::ST_APPLY |-> $onehot0(hit_q))
		else $error("one frame selected more than one channel");

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_chk
			mute_code_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				atten_pkg::channel_hit(latch_q.addr, 8'(g)) &&
				latch_q.code >= atten_pkg::MUTE_FIRST) |=> ##1
				chan_q[g].mute && chan_q[g].level_hdb == 8'hff)
				else $error("mute code did not mute the channel");

			fine_step_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				atten_pkg::channel_hit(latch_q.addr, 8'(g)) &&
				latch_q.code < 8'h20) |=> ##1
				!chan_q[g].mute && chan_q[g].level_hdb == $past(
				latch_q.code, 2))
				else $error("fine code gave the wrong level");

			max_level_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				atten_pkg::channel_hit(latch_q.addr, 8'(g)) &&
				latch_q.code == 8'h4e) |=> ##1
				!chan_q[g].mute && chan_q[g].level_hdb == 8'h98)
				else $error("deepest code is not 76 dB");

			miss_addr_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				!atten_pkg::channel_hit(latch_q.addr, 8'(g))) |=> ##1
				$stable(chan_q[g]))
				else $error("unaddressed channel changed");

			tap_code_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				atten_pkg::channel_hit(latch_q.addr, 8'(g)) &&
				latch_q.code < atten_pkg::MUTE_FIRST) |=> ##1
				chan_q[g].tap == $past(latch_q.code[6:0], 2))
				else $error("channel tap does not follow the code");

			mid_step_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				atten_pkg::channel_hit(latch_q.addr, 8'(g)) &&
				latch_q.code == 8'h21) |=> ##1
				!chan_q[g].mute && chan_q[g].level_hdb == 8'h22)
				else $error("second whole dB step is not 17 dB");

			coarse_step_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				(state_q == atten_pkg::ST_LATCHED &&
				atten_pkg::channel_hit(latch_q.addr, 8'(g)) &&
				latch_q.code == 8'h40) |=> ##1
				!chan_q[g].mute && chan_q[g].level_hdb == 8'h60)
				else $error("first coarse step is not 48 dB");

			mute_flag_a: assert property (
				@(posedge clk) disable iff (!rst_n)
				chan_q[g].mute |->
				chan_q[g].tap == atten_pkg::MUTE_TAP &&
				chan_q[g].level_hdb == atten_pkg::MUTE_HDB)
				else $error("muted channel shows a live tap");
		end
	endgenerate
endmodule

// ===== logic/atten_pkg.sv
// constants, types and decode helpers for the serial attenuator control
package atten_pkg;
	localparam int FRAME_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int CHANNELS = 3;
	localparam int PIN_COUNT = 3;

	// synchroniser reset: frame enable idles high, clock and data low
	localparam logic [2:0] PIN_RESET = 3'h4;
	localparam logic [1:0] RST_SYNC_RESET = 2'h0;
	localparam logic [15:0] SHIFT_RESET = 16'h0000;

	// channel one answers the base address, the others follow it
	localparam logic [7:0] CH_BASE_ADDR = 8'h00;

	// code ranges of the attenuation byte
	localparam logic [7:0] MID_FIRST = 8'h20;
	localparam logic [7:0] COARSE_FIRST = 8'h40;
	localparam logic [7:0] MUTE_FIRST = 8'h4f;

	// levels in half dB units
	localparam logic [7:0] MID_BASE_HDB = 8'h20;
	localparam logic [7:0] COARSE_BASE_HDB = 8'h60;
	localparam logic [7:0] MUTE_HDB = 8'hff;
	localparam logic [6:0] MUTE_TAP = 7'h4f;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] code;
	} frame_t;

	typedef struct packed {
		logic mute;
		logic [6:0] tap;
		logic [7:0] level_hdb;
	} channel_setting_t;

	localparam channel_setting_t MUTE_SETTING = '{
		mute: 1'b1,
		tap: MUTE_TAP,
		level_hdb: MUTE_HDB
	};

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_LATCHED = 3'h2,
		ST_APPLY = 3'h4
	} ctrl_state_t;

	// attenuation code to level in half dB; mute codes give MUTE_HDB
	function automatic logic [7:0] code_to_hdb(input logic [7:0] code);
		logic [7:0] lvl;
		lvl = code;
		if (code >= MUTE_FIRST)
			lvl = MUTE_HDB;
		else if (code >= COARSE_FIRST)
			lvl = COARSE_BASE_HDB + {code[5:0], 2'h0};
		else if (code >= MID_FIRST)
			lvl = MID_BASE_HDB + {2'h0, code[4:0], 1'h0};
		return lvl;
	endfunction

	// true when the address byte selects channel idx
	function automatic logic channel_hit(input logic [7:0] addr,
		input logic [7:0] idx);
		return addr == (CH_BASE_ADDR + idx);
	endfunction
endpackage

// ===== logic/pin_sync.sv
// two-stage synchroniser for the asynchronous serial pins
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	assign synced = sync_q;
endmodule

// ===== tb/atten_host.sv
// host model that drives the three-wire attenuator link
`timescale 1ns/100ps
module atten_host (
	input wire logic clk,
	output logic sclk,
	output logic sdi,
	output logic frame_en_n
);
	// link clock rests low and enable high between frames
	initial
	begin
		sclk = 1'b0;
		sdi = 1'b0;
		frame_en_n = 1'b1;
	end

	// one 64 ns bit: data set in the low half, rising edge mid bit
	task automatic put_bit(input logic b);
	begin
		sdi <= b;
		repeat (8) @(posedge clk);
		sclk <= 1'b1;
		repeat (8) @(posedge clk);
		sclk <= 1'b0;
	end
	endtask

	// enable drops well ahead of the first link clock
	task automatic open_frame();
	begin
		frame_en_n <= 1'b0;
		repeat (38) @(posedge clk);
	end
	endtask

	// enable rises once for the whole chain; data is stale after it
	task automatic close_frame();
	begin
		repeat (4) @(posedge clk);
		frame_en_n <= 1'b1;
		sdi <= ~sdi;
	end
	endtask

	// clock pulses with the enable high, which the device must ignore;
	// data is held high so a wrongly taken edge shows on the next frame
	task automatic stray_clocks();
	begin
		sdi <= 1'b1;
		repeat (3)
		begin
			sclk <= 1'b1;
			repeat (8) @(posedge clk);
			sclk <= 1'b0;
			repeat (8) @(posedge clk);
		end
	end
	endtask
endmodule

// ===== tb/serial_attenuator_control_bench.sv
// self-checking bench for the serial attenuator control
`timescale 1ns/100ps
module serial_attenuator_control_bench;
	logic clk;
	logic resetn;
	logic sclk;
	logic sdi;
	logic frame_en_n;
	logic sdo;
	atten_pkg::frame_t held_frame;
	atten_pkg::channel_setting_t [2:0] chan;
	int bad_count;
	int samples_checked;
	logic [15:0] m_shift;
	logic [15:0] m_chan [3];
	int codes [10];

	atten_host u_host (
		.clk(clk),
		.sclk(sclk),
		.sdi(sdi),
		.frame_en_n(frame_en_n)
	);

	serial_attenuator_control u_dut (
		.clk(clk),
		.resetn(resetn),
		.sclk(sclk),
		.sdi(sdi),
		.frame_en_n(frame_en_n),
		.sdo(sdo),
		.held_frame(held_frame),
		.chan(chan)
	);

	// 250 MHz system clock
	initial
		clk = 1'b0;
	always #2 clk = ~clk;

	task automatic print_verdict();
	begin
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
	begin
		samples_checked++;
		if (seen !== want)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	end
	endtask

	// reference setting for a code: fine, mid and coarse steps, then mute
	function automatic logic [15:0] setting_of(input int c);
		int lv;
		if (c >= 'h4f)
			return 16'hcfff;
		lv = c < 'h20 ? c : c < 'h40 ? 32 + 2 * (c - 'h20)
			: 96 + 4 * (c - 'h40);
		return {1'b0, 7'(c), 8'(lv)};
	endfunction

	// every shifted bit moves the next bit to the top, which the chain output then shows
	task automatic shift_word(input logic [15:0] w);
	begin
		for (int i = 15; i >= 0; i--)
		begin
			u_host.put_bit(w[i]);
			m_shift = {m_shift[14:0], w[i]};
			check({15'h0, sdo}, {15'h0, m_shift[15]});
		end
	end
	endtask

	// latch, then only the addressed channel may move
	task automatic latch_check();
	begin
		u_host.close_frame();
		repeat (8) @(posedge clk);
		if (m_shift[15:8] < 8'h03)
			m_chan[m_shift[15:8]] = setting_of(int'(m_shift[7:0]));
		check(held_frame, m_shift);
		for (int k = 0; k < 3; k++)
			check(chan[k], m_chan[k]);
	end
	endtask

	task automatic frame(input logic [7:0] a, input logic [7:0] c);
	begin
		u_host.open_frame();
		shift_word({a, c});
		latch_check();
	end
	endtask

	initial
	begin
		resetn = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		m_shift = 16'h0000;
		for (int k = 0; k < 3; k++)
			m_chan[k] = 16'hcfff;
		codes = '{'h03, 'h1e, 'h1f, 'h20, 'h3f, 'h40, 'h4e, 'h4f, 'hff, 'h00};
		void'($urandom(32'h6035e3c8));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		// power-up state: all channels muted
		check(held_frame, 16'h0000);
		for (int k = 0; k < 3; k++)
			check(chan[k], m_chan[k]);
		// clocks with the enable high change nothing
		u_host.stray_clocks();
		check({15'h0, sdo}, 16'h0000);
		check(held_frame, 16'h0000);
		// every code range on rotating channels
		foreach (codes[i])
			frame(8'(i % 3), 8'(codes[i]));
		// unmatched addresses leave all settings alone
		frame(8'h05, 8'h10);
		frame(8'hff, 8'h4f);
		// two-device chain: 32 bits, the first word leaves on sdo
		u_host.open_frame();
		shift_word({8'h02, 8'h4e});
		shift_word({8'h01, 8'h21});
		latch_check();
		// random traffic, address 3 unmatched
		repeat (12)
			frame(8'($urandom_range(0, 3)), 8'($urandom_range(0, 'hff)));
		print_verdict();
	end

	// cut a hang short well beyond the expected run length
	initial
	begin
		#200000;
		bad_count++;
		print_verdict();
	end
endmodule
